/* cpcg_consts.vh */
/*
 * Constants for the CPU pointer and change guard block: I/O offsets,
 * guard signatures, field positions, reset values and window length.
 * Assumes a 4-bit CPU register offset and 8-bit I/O data.
 */
`ifndef CPCG_CONSTS_VH
`define CPCG_CONSTS_VH

// CPU register map offsets
`define CPCG_OFS_GUARD 4'h4
`define CPCG_OFS_EXT 4'hB
`define CPCG_OFS_SPL 4'hD
`define CPCG_OFS_SPH 4'hE
`define CPCG_OFS_FLAGS 4'hF

// Guard signatures
`define CPCG_SIG_IO 8'hD8
`define CPCG_SIG_SELFPROG 8'h9D

// Guard readback field positions
`define CPCG_GUARD_IO_BIT 0
`define CPCG_GUARD_SP_BIT 1

// Reset values
`define CPCG_RST_GUARD 8'h00
`define CPCG_RST_EXT 8'h00
`define CPCG_RST_FLAGS 8'h00
`define CPCG_RST_PTR 16'h0000

// Guard window in executed instructions
`define CPCG_WINDOW_INSTR 3'h4

// Working register index of the first pointer low byte
`define CPCG_PTR_BASE 5'h1A

// Pointer usage forms
`define CPCG_MODE_PLAIN 2'h0
`define CPCG_MODE_DISP 2'h1
`define CPCG_MODE_POSTINC 2'h2
`define CPCG_MODE_PREDEC 2'h3

`endif

/* cpcg_pointer_guard.v */
/*
 * Pointer pairs, pointer extension byte, stack top pointer, result
 * flags and the configuration change guard of an 8-bit CPU core.
 * Assumes the CPU execute stage drives the I/O, working register,
 * pointer and retire strobes synchronously to ref_clk, one per cycle.
 */
`timescale 1ns/1ps
`include "cpcg_consts.vh"

module cpcg_pointer_guard #(
	parameter PROG_ADDR_BITS = 16, // Program memory byte address width
	parameter SP_BITS = 16, // Implemented stack pointer bits
	parameter [15:0] SP_RESET = 16'hFFFF // Top of stack after reset
) (
	input wire ref_clk, // CPU clock
	input wire rst, // Asynchronous reset, high
	input wire [3:0] ioAddr, // CPU register offset
	input wire ioWrEn, // I/O write strobe
	input wire [7:0] ioWrData, // I/O write data
	input wire ioRdEn, // I/O read strobe
	output reg [7:0] ioRdData_q, // I/O read data
	input wire regWrEn, // Working register write strobe
	input wire [4:0] regWrIdx, // Working register index
	input wire [7:0] regWrData, // Working register data
	input wire regRdEn, // Pointer byte read strobe
	input wire [4:0] regRdIdx, // Working register index to read
	output reg [7:0] regRdData_q, // Pointer byte read data
	input wire ptrOpEn, // Load/store pointer access
	input wire [1:0] ptrSel, // 0 first, 1 second, 2 third pointer
	input wire [1:0] ptrMode, // Usage form
	input wire [5:0] ptrDisp, // Fixed displacement
	output reg [15:0] dataAddr_q, // Data memory address
	output reg dataAddrValid_q, // Data address strobe
	input wire progRdEn, // Program memory read
	input wire progRdExt, // Extended form of the read
	output reg [23:0] progAddr_q, // Program memory byte address
	output reg progAddrValid_q, // Program address strobe
	input wire instrDone, // One instruction retired
	input wire instrIsWrite, // Retired instruction was a write
	output reg ioUnlock_q, // Protected I/O writes allowed
	output reg selfProgUnlock_q, // Self-programming allowed
	output reg intHold_q // Interrupt service held off
);

	////////////////////////////////////////////////////////////////
	// Implemented width of the extension byte
	localparam EXT_BITS = (PROG_ADDR_BITS > 16) ? PROG_ADDR_BITS - 16 : 0;
	localparam [8:0] EXT_FULL = 9'h001 << EXT_BITS;
	localparam [7:0] EXT_MASK = EXT_FULL[7:0] - 8'h01;
	localparam [16:0] SP_FULL = 17'h0_0001 << SP_BITS;
	localparam [15:0] SP_MASK = SP_FULL[15:0] - 16'h0001;

	// Guard states
	localparam [1:0] GUARD_IDLE = 2'h0;
	localparam [1:0] GUARD_IO = 2'h1;
	localparam [1:0] GUARD_SP = 2'h2;

	// Register state and next values
	reg [7:0] ext_q;
	reg [7:0] ext_d;
	reg [15:0] sp_q;
	reg [15:0] sp_d;
	reg [7:0] flags_q;
	reg [7:0] flags_d;
	reg [1:0] guardSt_q;
	reg [1:0] guardSt_d;
	reg [2:0] winCnt_q;
	reg [2:0] winCnt_d;
	reg ioUnlock_d;
	reg selfProgUnlock_d;
	reg [15:0] dataAddr_d;
	reg [23:0] progAddr_d;
	reg [7:0] rdMux;
	// Pointer, guard and readback nets
	wire [47:0] ptrFlat;
	wire [15:0] selPtr;
	wire [15:0] incPtr;
	wire [15:0] decPtr;
	wire ptrUpdate;
	wire [15:0] ptrNew;
	wire guardWr;
	wire sigIo;
	wire sigSp;
	wire winLast;
	wire extWr;
	wire splWr;
	wire sphWr;
	wire flagsWr;
	wire rdInPtr;
	wire [4:0] rdOfs;

	////////////////////////////////////////////////////////////////
	// Pointer pairs in the top six working registers
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : gPtr
			localparam integer LO_I = `CPCG_PTR_BASE + 2 * g;
			localparam integer SEL_I = g;
			localparam [4:0] LO_IDX = LO_I[4:0];
			localparam [4:0] HI_IDX = LO_IDX + 5'h01;
			localparam [1:0] SEL = SEL_I[1:0];
			reg [15:0] val_q;
			// Which of the three writers hits this pair
			wire autoHit = ptrUpdate && ptrSel == SEL;
			wire loHit = regWrEn && regWrIdx == LO_IDX;
			wire hiHit = regWrEn && regWrIdx == HI_IDX;
			// Auto update from a load/store wins over a plain register write
			always @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					val_q <= `CPCG_RST_PTR;
				end else if (autoHit) begin
					val_q <= ptrNew;
				end else if (loHit) begin
					val_q[7:0] <= regWrData;
				end else if (hiHit) begin
					val_q[15:8] <= regWrData;
				end
			end
			// Pointer value seen by the arithmetic and readback
			assign ptrFlat[16 * g +: 16] = val_q;
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Pointer arithmetic for the four usage forms
	assign selPtr = (ptrSel == 2'h3) ? 16'h0000 : ptrFlat[16 * ptrSel +: 16];
	assign incPtr = selPtr + 16'h0001;
	assign decPtr = selPtr - 16'h0001;
	assign ptrUpdate = ptrOpEn && ptrSel != 2'h3 &&
		(ptrMode == `CPCG_MODE_POSTINC || ptrMode == `CPCG_MODE_PREDEC);
	assign ptrNew = (ptrMode == `CPCG_MODE_POSTINC) ? incPtr : decPtr;

	// Data memory address for each usage form
	always @* begin
		dataAddr_d = dataAddr_q;
		if (ptrOpEn) begin
			case (ptrMode)
				`CPCG_MODE_DISP: dataAddr_d = selPtr + {10'h000, ptrDisp};
				`CPCG_MODE_PREDEC: dataAddr_d = decPtr;
				`CPCG_MODE_POSTINC: dataAddr_d = selPtr;
				default: dataAddr_d = selPtr;
			endcase
		end
	end

	// Data address and strobe; no strobe when no pointer is selected
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dataAddr_q <= 16'h0000;
			dataAddrValid_q <= 1'b0;
		end else begin
			dataAddr_q <= dataAddr_d;
			dataAddrValid_q <= ptrOpEn && ptrSel != 2'h3;
		end
	end

	////////////////////////////////////////////////////////////////
	// Program address; only the extended form uses the extension byte
	always @* begin
		progAddr_d = progAddr_q;
		if (progRdEn && progRdExt) begin
			progAddr_d = {ext_q, ptrFlat[47:32]};
		end else if (progRdEn) begin
			progAddr_d = {8'h00, ptrFlat[47:32]};
		end
	end

	// Program address and strobe registers
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			progAddr_q <= 24'h00_0000;
			progAddrValid_q <= 1'b0;
		end else begin
			progAddr_q <= progAddr_d;
			progAddrValid_q <= progRdEn;
		end
	end

	////////////////////////////////////////////////////////////////
	// Change guard decode
	assign guardWr = ioWrEn && ioAddr == `CPCG_OFS_GUARD;
	assign sigIo = guardWr && ioWrData == `CPCG_SIG_IO;
	assign sigSp = guardWr && ioWrData == `CPCG_SIG_SELFPROG;
	assign winLast = instrIsWrite || winCnt_q == 3'h1;

	// Guard state and window counter next state
	always @* begin
		guardSt_d = guardSt_q;
		winCnt_d = winCnt_q;
		if (sigIo) begin
			guardSt_d = GUARD_IO;
			winCnt_d = `CPCG_WINDOW_INSTR;
		end else if (sigSp) begin
			guardSt_d = GUARD_SP;
			winCnt_d = `CPCG_WINDOW_INSTR;
		end else begin
			case (guardSt_q)
				GUARD_IDLE: begin
					winCnt_d = 3'h0;
				end
				GUARD_IO, GUARD_SP: begin
					if (instrDone && winLast) begin
						guardSt_d = GUARD_IDLE;
						winCnt_d = 3'h0;
					end else if (instrDone) begin
						winCnt_d = winCnt_q - 3'h1;
					end
				end
				default: begin
					guardSt_d = GUARD_IDLE;
					winCnt_d = 3'h0;
				end
			endcase
		end
	end

	// Unlock levels follow the next state so the outputs stay registered
	always @* begin
		ioUnlock_d = guardSt_d == GUARD_IO;
		selfProgUnlock_d = guardSt_d == GUARD_SP;
	end

	// Guard state; protected logic sees the unlock outputs only
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			guardSt_q <= GUARD_IDLE;
			winCnt_q <= 3'h0;
			ioUnlock_q <= 1'b0;
			selfProgUnlock_q <= 1'b0;
			intHold_q <= 1'b0;
		end else begin
			guardSt_q <= guardSt_d;
			winCnt_q <= winCnt_d;
			ioUnlock_q <= ioUnlock_d;
			selfProgUnlock_q <= selfProgUnlock_d;
			intHold_q <= guardSt_d != GUARD_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////
	// Write decode; reserved offsets match no register
	assign extWr = ioWrEn && ioAddr == `CPCG_OFS_EXT;
	assign splWr = ioWrEn && ioAddr == `CPCG_OFS_SPL;
	assign sphWr = ioWrEn && ioAddr == `CPCG_OFS_SPH;
	assign flagsWr = ioWrEn && ioAddr == `CPCG_OFS_FLAGS;

	// Next values of the writable registers
	always @* begin
		ext_d = ext_q;
		sp_d = sp_q;
		flags_d = flags_q;
		if (extWr) begin
			ext_d = ioWrData & EXT_MASK;
		end
		if (splWr) begin
			sp_d = {sp_q[15:8], ioWrData} & SP_MASK;
		end
		if (sphWr) begin
			sp_d = {ioWrData, sp_q[7:0]} & SP_MASK;
		end
		if (flagsWr) begin
			flags_d = ioWrData;
		end
	end

	// Register state
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ext_q <= `CPCG_RST_EXT;
			sp_q <= SP_RESET & SP_MASK;
			flags_q <= `CPCG_RST_FLAGS;
		end else begin
			ext_q <= ext_d;
			sp_q <= sp_d;
			flags_q <= flags_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// I/O readback
	always @* begin
		rdMux = 8'h00;
		case (ioAddr)
			`CPCG_OFS_GUARD: begin
				rdMux[`CPCG_GUARD_IO_BIT] = ioUnlock_q;
				rdMux[`CPCG_GUARD_SP_BIT] = selfProgUnlock_q;
			end
			`CPCG_OFS_EXT: rdMux = ext_q;
			`CPCG_OFS_SPL: rdMux = sp_q[7:0];
			`CPCG_OFS_SPH: rdMux = sp_q[15:8];
			`CPCG_OFS_FLAGS: rdMux = flags_q;
			default: rdMux = 8'h00;
		endcase
	end

	// Read data holds until the next read
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ioRdData_q <= 8'h00;
		end else if (ioRdEn) begin
			ioRdData_q <= rdMux;
		end
	end

	////////////////////////////////////////////////////////////////
	// Pointer byte readback by working register index
	assign rdOfs = regRdIdx - `CPCG_PTR_BASE;
	assign rdInPtr = regRdIdx >= `CPCG_PTR_BASE;

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			regRdData_q <= 8'h00;
		end else if (regRdEn) begin
			if (rdInPtr) begin
				regRdData_q <= ptrFlat[8 * rdOfs +: 8];
			end else begin
				regRdData_q <= 8'h00;
			end
		end
	end

endmodule // cpcg_pointer_guard

/* cpcg_pg_asserts.sv */
/*
 * Checker for the pointer and change guard block.
 * Assumes binding to the top module, sole clock ref_clk.
 */
`timescale 1ns/1ps
module cpcg_pg_asserts (
	input wire ref_clk, // Clock
	input wire rst, // Reset
	input wire [3:0] ioAddr, // Offset
	input wire ioWrEn, // Write
	input wire [7:0] ioWrData, // Data
	input wire ioRdEn, // Read
	input wire [7:0] ioRdData_q, // Read data
	input wire ptrOpEn, // Pointer op
	input wire [1:0] ptrSel, // Pointer
	input wire dataAddrValid_q, // Address strobe
	input wire instrDone, // Retire
	input wire instrIsWrite, // Write retire
	input wire ioUnlock_q, // I/O open
	input wire selfProgUnlock_q, // Self-prog open
	input wire intHold_q // Hold
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	// Valid signature write to the guard
	wire guardSig = ioWrEn && ioAddr == 4'h4 && (ioWrData == 8'hD8 || ioWrData == 8'h9D);
	wire open = ioUnlock_q || selfProgUnlock_q;
	chk_io_sig: assert property (guardSig && ioWrData == 8'hD8 |=> ioUnlock_q && !selfProgUnlock_q)
		else $error("io unlock missed");
	chk_sp_sig: assert property (guardSig && ioWrData == 8'h9D |=> selfProgUnlock_q && !ioUnlock_q)
		else $error("self-prog unlock missed");
	chk_hold_open: assert property (intHold_q == open)
		else $error("hold not tied to window");
	chk_write_close: assert property (open && instrDone && instrIsWrite && !guardSig |=> !open)
		else $error("window open after write");
	chk_no_sig: assert property (!guardSig && !ioUnlock_q |=> !ioUnlock_q)
		else $error("unlock without signature");
	chk_guard_read: assert property (ioRdEn && ioAddr == 4'h4 |=>
		ioRdData_q == {6'h0, $past(selfProgUnlock_q), $past(ioUnlock_q)})
		else $error("guard readback wrong");
	chk_rsvd_read: assert property (ioRdEn && !(ioAddr inside {4'h4, 4'hB, 4'hD, 4'hE, 4'hF})
		|=> ioRdData_q == 8'h00)
		else $error("reserved read not zero");
	chk_ptr_pulse: assert property (ptrOpEn && ptrSel != 2'h3 |=> dataAddrValid_q)
		else $error("no data address strobe");
endmodule // cpcg_pg_asserts

/* cpcg_cpu_model.sv */
/*
 * CPU retire model: raises one retire pulse per call.
 * Assumes the bench calls retire from its main sequence.
 */
`timescale 1ns/1ps
module cpcg_cpu_model (
	input wire ref_clk, // Clock
	output reg instrDone, // Retire pulse
	output reg instrIsWrite // Retired a write
);
	initial begin
		instrDone = 1'h0;
		instrIsWrite = 1'h0;
	end
	// One instruction; software stays within four
	task automatic retire(input logic wr);
		@(posedge ref_clk);
		instrDone <= 1'h1;
		instrIsWrite <= wr;
		@(posedge ref_clk);
		instrDone <= 1'h0;
		instrIsWrite <= 1'h0;
	endtask
endmodule // cpcg_cpu_model

/* tb.sv */
/*
 * Self-checking bench for the pointer and change guard block.
 * Assumes the checker and CPU model files compile first.
 */
`timescale 1ns/1ps
module tb;
	logic ref_clk, rst, ioWrEn, ioRdEn, regWrEn, ptrOpEn, progRdEn, progRdExt, rdSeen;
	logic regRdEn, rgSeen;
	logic [3:0] ioAddr;
	logic [7:0] ioWrData, regWrData;
	logic [4:0] regWrIdx, regRdIdx;
	wire [7:0] regRdData_q;
	logic [1:0] ptrSel, ptrMode;
	logic [5:0] ptrDisp;
	logic [15:0] z, w;
	logic [23:0] expQ[$];
	wire [7:0] ioRdData_q;
	wire [15:0] dataAddr_q;
	wire [23:0] progAddr_q;
	wire dataAddrValid_q, progAddrValid_q, instrDone, instrIsWrite;
	wire ioUnlock_q, selfProgUnlock_q, intHold_q;
	int errors, cmp_count, cyc;
	cpcg_pointer_guard #(.PROG_ADDR_BITS(24)) u_cpcg_pointer_guard (.ref_clk, .rst, .ioAddr,
		.ioWrEn, .ioWrData, .ioRdEn, .ioRdData_q, .regWrEn, .regWrIdx, .regWrData,
		.regRdEn, .regRdIdx, .regRdData_q, .ptrOpEn, .ptrSel, .ptrMode,
		.ptrDisp, .dataAddr_q, .dataAddrValid_q, .progRdEn, .progRdExt, .progAddr_q,
		.progAddrValid_q, .instrDone, .instrIsWrite, .ioUnlock_q, .selfProgUnlock_q, .intHold_q);
	cpcg_cpu_model u_cpcg_cpu_model (.ref_clk, .instrDone, .instrIsWrite);
	////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic print_verdict;
		$display("compares %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Register bus cycle; a read notes its expected data
	task automatic io(input logic wr, input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		ioWrEn <= wr;
		ioRdEn <= !wr;
		ioAddr <= a;
		ioWrData <= d;
		if (!wr) expQ.push_back({16'h0000, d});
		@(posedge ref_clk);
		ioWrEn <= 1'h0;
		ioRdEn <= 1'h0;
	endtask
	task automatic regw(input logic [4:0] i, input logic [7:0] d);
		@(posedge ref_clk);
		regWrEn <= 1'h1;
		regWrIdx <= i;
		regWrData <= d;
		@(posedge ref_clk);
		regWrEn <= 1'h0;
	endtask
	// Pointer byte read by working register index; notes the expected byte
	task automatic regr(input logic [4:0] i, input logic [7:0] e);
		@(posedge ref_clk);
		regRdEn <= 1'h1;
		regRdIdx <= i;
		expQ.push_back({16'h0000, e});
		@(posedge ref_clk);
		regRdEn <= 1'h0;
	endtask
	task automatic ptr(input logic [1:0] s, input logic [1:0] m, input logic [5:0] d,
		input logic [15:0] e);
		@(posedge ref_clk);
		ptrOpEn <= 1'h1;
		ptrSel <= s;
		ptrMode <= m;
		ptrDisp <= d;
		if (s != 2'h3) expQ.push_back({8'h00, e});
		@(posedge ref_clk);
		ptrOpEn <= 1'h0;
	endtask
	task automatic prog(input logic x, input logic [23:0] e);
		@(posedge ref_clk);
		progRdEn <= 1'h1;
		progRdExt <= x;
		expQ.push_back(e);
		@(posedge ref_clk);
		progRdEn <= 1'h0;
	endtask
	// Guard levels {hold, self-prog, io} after the last edge
	task automatic lvl(input logic [2:0] e);
		@(negedge ref_clk);
		check("guard", {21'h0, intHold_q, selfProgUnlock_q, ioUnlock_q}, e);
	endtask
	// Clock and cycle ceiling
	initial begin
		ref_clk = 1'h0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			print_verdict;
		end
	end
	// Result watcher takes the oldest note per result
	always @(negedge ref_clk) begin
		if (rdSeen || rgSeen || dataAddrValid_q === 1'h1 || progAddrValid_q === 1'h1) begin
			check("result", rdSeen ? {16'h0000, ioRdData_q} : rgSeen ? {16'h0000, regRdData_q} :
				progAddrValid_q ? progAddr_q : {8'h00, dataAddr_q},
				expQ.pop_front());
		end
		rdSeen <= ioRdEn;
		rgSeen <= regRdEn;
	end
	// Main sequence
	initial begin
		{ioWrEn, ioRdEn, regWrEn, regRdEn, ptrOpEn, progRdEn, progRdExt} = '0;
		{ioAddr, ioWrData, regWrIdx, regRdIdx, regWrData, ptrSel, ptrMode, ptrDisp} = '0;
		rst = 1'h1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'h0;
		void'($urandom(32'h8fa1_3c5b));
		z = $urandom;
		w = $urandom;
		regw(5'h1e, z[7:0]);
		regw(5'h1f, z[15:8]);
		regw(5'h1a, w[7:0]);
		regw(5'h1b, w[15:8]);
		ptr(2'h0, 2'h0, 6'h00, w);
		ptr(2'h2, 2'h2, 6'h00, z);
		ptr(2'h2, 2'h3, 6'h00, z);
		ptr(2'h3, 2'h0, 6'h00, z);
		ptr(2'h2, 2'h1, w[5:0], z + w[5:0]);
		regr(5'h1e, z[7:0]);
		regr(5'h1f, z[15:8]);
		regr(5'h1a, w[7:0]);
		regr(5'h1d, 8'h00);
		$display("test pointers done");
		io(1'h1, 4'hb, 8'h05);
		io(1'h0, 4'hb, 8'h05);
		prog(1'h1, {8'h05, z});
		prog(1'h0, {8'h00, z});
		$display("test program reads done");
		io(1'h1, 4'h4, 8'h55);
		lvl(3'h0);
		io(1'h1, 4'h4, 8'hd8);
		lvl(3'h5);
		io(1'h0, 4'h4, 8'h01);
		u_cpcg_cpu_model.retire(1'h1);
		lvl(3'h0);
		io(1'h1, 4'h4, 8'h9d);
		io(1'h0, 4'h4, 8'h02);
		repeat (3) u_cpcg_cpu_model.retire(1'h0);
		lvl(3'h6);
		u_cpcg_cpu_model.retire(1'h0);
		lvl(3'h0);
		$display("test guard done");
		for (int a = 0; a < 16; a++) begin
			if (16'h17ef >> a & 1) begin
				io(1'h1, a[3:0], 8'hff);
				io(1'h0, a[3:0], 8'h00);
			end
		end
		$display("test reserved done");
		repeat (3) @(posedge ref_clk);
		print_verdict;
	end
endmodule // tb
bind cpcg_pointer_guard cpcg_pg_asserts u_cpcg_pg_asserts (.ref_clk, .rst, .ioAddr, .ioWrEn,
	.ioWrData, .ioRdEn, .ioRdData_q, .ptrOpEn, .ptrSel, .dataAddrValid_q, .instrDone,
	.instrIsWrite, .ioUnlock_q, .selfProgUnlock_q, .intHold_q);
